// >>> core/gpib_status_regs.svh
// Constants for the status and message-execution control block
// How it works
// - Header enable on adds headers to query responses; off omits them; resets on.
// - Settings response always carries headers, whatever the header enable says.
// - Hold command makes busy, stops input, defers following commands.
// - Hold ends once end-of-sweep is present.
// - Single-sweep mode and not armed: hold is skipped and execution goes on.
// - Device clear, or selected clear while listener, ends hold and flushes buffers.
// - Repeat re-runs preceding units an extra 0 to 2^24-1 times.
// - An earlier nested repeat runs only on the outer loop's first pass.
// - Only device clear, or selected clear while listener, stops a loop; local return caps it at 256 repeats.
// - Sweep-end enable and service enable on: SRQ on sweep completion; resets off.
// - Service enable on: SRQ on abnormal status; off masks it; resets on.
// - Service enable forced off in talk-only or listen-only mode.
// - Warning enable off drops warning codes; on passes them; resets on.
// - Talker plus serial poll enable puts the status byte on the bus.
// - Bit 7 shows SRQ, bit 5 busy, bits 4 to 1 the status code.
// - Sweep completion with storage updated reports code 0010, bit 6 clear.
// - Nothing pending reports code 0000, bit 6 clear.
// - Power-on status 0001 with SRQ only when the option switch selects it; unmaskable.
// - Unparsable message gives abnormal code 0001; unexecutable gives 0010.
// - Abnormal codes 0011 malfunction, 0101 executed warning, 0110 internal warning.
// - Serial poll clears the reported byte; next stacked condition may request at once.
// - While busy, no device-dependent input; NRFD held if listen-addressed.
`ifndef GPIB_STATUS_REGS_SVH
`define GPIB_STATUS_REGS_SVH

// Status codes
`define CODE_ORDINARY   4'h0
`define CODE_POWER_ON   4'h1
`define CODE_SWEEP_END  4'h2
`define CODE_CMD_ERR    4'h1
`define CODE_EXEC_ERR   4'h2
`define CODE_INT_ERR    4'h3
`define CODE_EXEC_WARN  4'h5
`define CODE_INT_WARN   4'h6

// Status byte field positions
`define SB_SRQ_BIT      6
`define SB_ABN_BIT      5
`define SB_BUSY_BIT     4

// Settings reset values
`define RST_HDR_EN      1'b1
`define RST_EOS_EN      1'b0
`define RST_RQS_EN      1'b1
`define RST_WARN_EN     1'b1

// Repeat limits and condition stack size
`define REPEAT_W        24
`define LOCAL_CAP       9'h100
`define POS_W           8
`define STACK_DEPTH     8
`define STACK_AW        3

`endif

// >>> core/gpib_status_pkg.sv
// Types for the status and message-execution control block
`include "gpib_status_regs.svh"
package gpib_status_pkg;

    typedef enum logic [0:0] {
        EXEC_RUN,
        EXEC_HOLD
    } exec_state_t;

    // One stacked condition: power-on flag, abnormal flag, code
    typedef struct packed {
        logic       powerOn;
        logic       abnormal;
        logic [3:0] code;
    } cond_t;

    typedef struct packed {
        logic                    hdrEnable;
        logic                    eosEnable;
        logic                    rqsEnable;
        logic                    warnEnable;
        exec_state_t             execState;
        logic                    loopActive;
        logic [`POS_W-1:0]       loopPos;
        logic [`REPEAT_W-1:0]    remaining;
        logic                    capped;
        logic [8:0]              passCount;
        logic                    replay;
        logic                    proceed;
        logic                    flush;
        logic                    busy;
        logic                    nrfdHold;
        logic                    acceptInput;
        logic                    headerEmit;
        logic                    srq;
        logic [7:0]              statusByte;
        logic [`STACK_AW-1:0]    wrPtr;
        logic [`STACK_AW-1:0]    rdPtr;
        logic [`STACK_AW:0]      count;
        logic                    powerOnPending;
    } ctrl_state_t;

endpackage : gpib_status_pkg

// >>> core/status_stack_mem.sv
// Small memory holding stacked status conditions, registered read
module status_stack_mem #(
    parameter int WIDTH = 6,
    parameter int AW    = 3
) (
    input  wire logic             clk_sys,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write, and read with write-through so a fresh entry shows at once
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (we && waddr == raddr) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule : status_stack_mem

// >>> core/gpib_status_and_exec_control.sv
// Message execution control and serial-poll status reporting
`include "gpib_status_regs.svh"
module gpib_status_and_exec_control
    import gpib_status_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire logic                 settingsInit,
    input  wire logic                 setHeader,
    input  wire logic                 setSweepEndReq,
    input  wire logic                 setServiceReq,
    input  wire logic                 setWarnReport,
    input  wire logic                 setValue,
    input  wire logic                 settingsQuery,

    input  wire logic                 talkOnly,
    input  wire logic                 listenOnly,
    input  wire logic                 listenAddressed,

    input  wire logic                 optionPowerOn,

    input  wire logic                 execBusy,
    input  wire logic                 holdCmd,
    input  wire logic                 singleSweepMode,
    input  wire logic                 single_sweep_arm,
    input  wire logic                 sweepEndPresent,
    input  wire logic                 sweepDone,

    input  wire logic                 deviceClear,
    input  wire logic                 selDeviceClear,
    input  wire logic                 repeatCmd,
    input  wire logic [`POS_W-1:0]    repeatPos,
    input  wire logic [`REPEAT_W-1:0] repeatCount,
    input  wire logic                 local_return_button,

    input  wire logic                 cmdError,
    input  wire logic                 execError,
    input  wire logic                 internalError,
    input  wire logic                 execWarning,
    input  wire logic                 internalWarning,
    input  wire logic                 serialPoll,

    output logic                      query_header_enable,
    output logic                      sweep_end_request_enable,
    output logic                      service_request_enable,
    output logic                      warning_report_enable,

    output logic                      headerEmit,
    output logic                      busy,
    output logic                      acceptInput,
    output logic                      nrfdHold,
    output logic                      flushBuffers,
    output logic                      replay,
    output logic                      proceed,

    output logic                      srq,
    output logic [7:0]                statusByte
);
    ctrl_state_t st;
    ctrl_state_t next_st;
    cond_t       headCond;

    logic [5:0]  headData;
    logic        pushEn;
    cond_t       pushCond;
    logic        popEn;

    logic        clearAll;
    logic        rqsEff;
    logic        headEos;
    logic        headSrq;

    assign headCond = cond_t'(headData);

    // Stacked conditions, oldest at the read pointer
    status_stack_mem #(
        .WIDTH (6),
        .AW    (`STACK_AW)
    ) u_stack (
        .clk_sys (clk_sys),
        .we      (pushEn),
        .waddr   (st.wrPtr),
        .wdata   (pushCond),
        .raddr   (next_st.rdPtr),
        .rdata   (headData)
    );

    // Next-state logic
    always_comb begin
        next_st  = st;
        pushEn   = 1'b0;
        pushCond = '0;
        popEn    = 1'b0;

        next_st.replay  = 1'b0;
        next_st.proceed = 1'b0;
        next_st.flush   = 1'b0;

        clearAll = deviceClear || (selDeviceClear && listenAddressed);
        rqsEff   = st.rqsEnable && !(talkOnly || listenOnly);

        // Settings commands
        if (setHeader) begin
            next_st.hdrEnable = setValue;
        end

        if (setSweepEndReq) begin
            next_st.eosEnable = setValue;
        end

        if (setServiceReq) begin
            next_st.rqsEnable = setValue && !(talkOnly || listenOnly);
        end

        if (setWarnReport) begin
            next_st.warnEnable = setValue;
        end

        // Hold until end of sweep
        case (st.execState)
            EXEC_RUN: begin
                if (holdCmd && !clearAll) begin
                    if (singleSweepMode && !single_sweep_arm) begin
                        next_st.proceed = 1'b1;
                    end else if (sweepEndPresent) begin
                        next_st.proceed = 1'b1;
                    end else begin
                        next_st.execState = EXEC_HOLD;
                    end
                end
            end
            EXEC_HOLD: begin
                if (clearAll) begin
                    next_st.execState = EXEC_RUN;
                end else if (sweepEndPresent) begin
                    next_st.execState = EXEC_RUN;
                    next_st.proceed   = 1'b1;
                end
            end
            default: begin
                next_st.execState = EXEC_RUN;
            end
        endcase

        if (clearAll) begin
            next_st.flush = 1'b1;
        end

        // Repeat loop
        if (st.loopActive && local_return_button) begin
            next_st.capped = 1'b1;
        end

        if (clearAll) begin
            next_st.loopActive = 1'b0;
            next_st.capped     = 1'b0;
        end else if (repeatCmd) begin
            if (st.loopActive && repeatPos != st.loopPos) begin
                next_st.proceed = 1'b1;
            end else if (st.loopActive) begin
                if (st.remaining == '0 || (st.capped && st.passCount >= `LOCAL_CAP)) begin
                    next_st.loopActive = 1'b0;
                    next_st.capped     = 1'b0;
                    next_st.proceed    = 1'b1;
                end else begin
                    next_st.remaining = st.remaining - 1'b1;
                    if (st.passCount != `LOCAL_CAP) begin
                        next_st.passCount = st.passCount + 1'b1;
                    end
                    next_st.replay = 1'b1;
                end
            end else if (repeatCount == '0) begin
                next_st.proceed = 1'b1;
            end else begin
                next_st.loopActive = 1'b1;
                next_st.loopPos    = repeatPos;
                next_st.remaining  = repeatCount - 1'b1;
                next_st.passCount  = 9'h001;
                next_st.capped     = local_return_button;
                next_st.replay     = 1'b1;
            end
        end

        // Pick at most one new condition to stack
        if (st.powerOnPending) begin
            next_st.powerOnPending = 1'b0;
            if (optionPowerOn) begin
                pushEn   = 1'b1;
                pushCond = '{powerOn: 1'b1, abnormal: 1'b0, code: `CODE_POWER_ON};
            end
        end else if (cmdError) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b1, code: `CODE_CMD_ERR};
        end else if (execError) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b1, code: `CODE_EXEC_ERR};
        end else if (internalError) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b1, code: `CODE_INT_ERR};
        end else if (execWarning && st.warnEnable) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b1, code: `CODE_EXEC_WARN};
        end else if (internalWarning && st.warnEnable) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b1, code: `CODE_INT_WARN};
        end else if (sweepDone && st.eosEnable) begin
            pushEn   = 1'b1;
            pushCond = '{powerOn: 1'b0, abnormal: 1'b0, code: `CODE_SWEEP_END};
        end

        if (st.count == `STACK_DEPTH) begin
            pushEn = 1'b0;
        end

        // Serial poll removes the reported condition
        popEn = serialPoll && st.count != '0;

        if (pushEn) begin
            next_st.wrPtr = st.wrPtr + 1'b1;
        end
        if (popEn) begin
            next_st.rdPtr = st.rdPtr + 1'b1;
        end

        next_st.count = st.count + {{`STACK_AW{1'b0}}, pushEn} - {{`STACK_AW{1'b0}}, popEn};

        if (clearAll) begin
            next_st.count = '0;
            next_st.rdPtr = st.wrPtr + {{(`STACK_AW-1){1'b0}}, pushEn};
            next_st.wrPtr = next_st.rdPtr;
        end

        // Settings initialise restores power-up values
        if (settingsInit) begin
            next_st.hdrEnable  = `RST_HDR_EN;
            next_st.eosEnable  = `RST_EOS_EN;
            next_st.rqsEnable  = `RST_RQS_EN && !(talkOnly || listenOnly);
            next_st.warnEnable = `RST_WARN_EN;
        end

        if (talkOnly || listenOnly) begin
            next_st.rqsEnable = 1'b0;
        end

        // Busy, input gate and handshake hold
        next_st.busy        = (next_st.execState == EXEC_HOLD) || execBusy;
        next_st.acceptInput = !next_st.busy;
        next_st.nrfdHold    = next_st.busy && listenAddressed;

        next_st.headerEmit  = settingsQuery || next_st.hdrEnable;

        // Status byte from the oldest stacked condition
        headEos = !headCond.abnormal && headCond.code == `CODE_SWEEP_END;
        headSrq = st.count != '0 && (headCond.powerOn
                  || (rqsEff && headCond.abnormal)
                  || (rqsEff && st.eosEnable && headEos));

        next_st.srq = headSrq;
        next_st.statusByte = 8'h00;
        if (st.count != '0) begin
            next_st.statusByte[3:0] = headCond.code;
            next_st.statusByte[`SB_ABN_BIT] = headCond.abnormal;
        end else begin
            next_st.statusByte[3:0] = `CODE_ORDINARY;
        end

        next_st.statusByte[`SB_SRQ_BIT]  = headSrq;
        next_st.statusByte[`SB_BUSY_BIT] = st.busy;
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st                <= '0;
            st.hdrEnable      <= `RST_HDR_EN;
            st.eosEnable      <= `RST_EOS_EN;
            st.rqsEnable      <= `RST_RQS_EN;
            st.warnEnable     <= `RST_WARN_EN;
            st.execState      <= EXEC_RUN;
            st.acceptInput    <= 1'b1;
            st.headerEmit     <= 1'b1;
            st.powerOnPending <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state
    assign query_header_enable      = st.hdrEnable;
    assign sweep_end_request_enable = st.eosEnable;
    assign service_request_enable   = st.rqsEnable;
    assign warning_report_enable    = st.warnEnable;

    assign headerEmit               = st.headerEmit;
    assign busy                     = st.busy;
    assign acceptInput              = st.acceptInput;
    assign nrfdHold                 = st.nrfdHold;

    assign flushBuffers             = st.flush;

    assign replay                   = st.replay;
    assign proceed                  = st.proceed;
    assign srq                      = st.srq;
    assign statusByte               = st.statusByte;
endmodule : gpib_status_and_exec_control

// >>> sim/gpib_status_assertions.sv
// Port-level checks of execution control and status
module gpib_status_checker (
    input wire logic       clk_sys,
    input wire logic       srst,
    input wire logic       settingsInit,
    input wire logic       setServiceReq,
    input wire logic       settingsQuery,
    input wire logic       talkOnly,
    input wire logic       listenOnly,
    input wire logic       listenAddressed,
    input wire logic       execBusy,
    input wire logic       holdCmd,
    input wire logic       singleSweepMode,
    input wire logic       single_sweep_arm,
    input wire logic       sweepEndPresent,
    input wire logic       deviceClear,
    input wire logic       selDeviceClear,
    input wire logic       repeatCmd,
    input wire logic       service_request_enable,
    input wire logic       headerEmit,
    input wire logic       busy,
    input wire logic       acceptInput,
    input wire logic       flushBuffers,
    input wire logic       replay,
    input wire logic       proceed,
    input wire logic       srq,
    input wire logic [7:0] statusByte
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Hold and query steps
    sequence s_no_clear; !deviceClear && !selDeviceClear; endsequence
    sequence s_hold_wait; holdCmd && !sweepEndPresent && !(singleSweepMode && !single_sweep_arm); endsequence
    sequence s_query_held; settingsQuery ##1 settingsQuery; endsequence
    // Hold entry, skip and release
    property p_hold_busy; s_hold_wait ##0 s_no_clear |=> busy && !proceed; endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("hold not busy");
    property p_hold_skip; holdCmd && singleSweepMode && !single_sweep_arm && !execBusy ##0 s_no_clear |=> proceed && !busy; endproperty
    a_hold_skip: assert property (p_hold_skip) else $error("hold not skipped");
    property p_hold_end; busy && sweepEndPresent && !execBusy && !holdCmd |=> !busy; endproperty
    a_hold_end: assert property (p_hold_end) else $error("hold not ended");
    // Clears flush the buffers; a repeat gets exactly one answer
    property p_sdc_flush; selDeviceClear && !deviceClear |=> flushBuffers == $past(listenAddressed); endproperty
    a_sdc_flush: assert property (p_sdc_flush) else $error("sdc flush");
    property p_dcl_flush; deviceClear && !execBusy |=> flushBuffers && !busy; endproperty
    a_dcl_flush: assert property (p_dcl_flush) else $error("dcl flush");
    property p_repeat_one; repeatCmd && !holdCmd && !deviceClear |=> replay != proceed; endproperty
    a_repeat_one: assert property (p_repeat_one) else $error("repeat answer");
    // Status byte, input gate, settings header and forced service enable
    property p_busy_bit; statusByte[4] == $past(busy); endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit");
    property p_accept; acceptInput == !busy; endproperty
    a_accept: assert property (p_accept) else $error("accept while busy");
    property p_srq_bit; srq == statusByte[6] && !statusByte[7]; endproperty
    a_srq_bit: assert property (p_srq_bit) else $error("srq bit");
    property p_hdr_query; s_query_held |-> headerEmit; endproperty
    a_hdr_query: assert property (p_hdr_query) else $error("settings header");
    property p_rqs_forced; (talkOnly || listenOnly) && (setServiceReq || settingsInit) |=> !service_request_enable; endproperty
    a_rqs_forced: assert property (p_rqs_forced) else $error("rqs not forced");
endmodule : gpib_status_checker

bind gpib_status_and_exec_control gpib_status_checker u_checker (.*);

// >>> sim/gpib_controller_model.sv
// Bus controller model: polls, clears, listen address
module gpib_controller_model (
    input  wire logic       clk_sys,
    input  wire logic [7:0] statusByte,
    output logic            serialPoll,
    output logic            deviceClear,
    output logic            selDeviceClear,
    output logic            listenAddressed
);
    timeunit 1ns;
    timeprecision 1ns;
    // All lines idle at start
    initial {serialPoll, deviceClear, selDeviceClear, listenAddressed} = 4'h0;
    // Serial poll; byte taken at the poll edge
    task automatic poll(output logic [7:0] got);
        serialPoll <= 1'b1;
        @(posedge clk_sys);
        got = statusByte;
        serialPoll <= 1'b0;
    endtask : poll
    // Device clear, or selected clear
    task automatic clear(input logic sel);
        selDeviceClear <= sel;
        deviceClear <= !sel;
        @(posedge clk_sys);
        selDeviceClear <= 1'b0;
        deviceClear <= 1'b0;
    endtask : clear
    task automatic listen(input logic on);
        listenAddressed <= on;
    endtask : listen
endmodule : gpib_controller_model

// >>> sim/tb_top.sv
// Bench for execution control and status reporting
`include "gpib_status_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk_sys = 1'b0, srst = 1'b1, setValue = 1'b0, settingsQuery = 1'b0, talkOnly = 1'b0;
    logic                 listenOnly = 1'b0, optionPowerOn = 1'b0, execBusy = 1'b0, singleSweepMode = 1'b0;
    logic                 single_sweep_arm = 1'b0, sweepEndPresent = 1'b0, repeatCmd = 1'b0, local_return_button = 1'b0;
    logic [3:0]           sv = 4'h0;
    logic [7:0]           pv = 8'h00, got, statusByte;
    logic [`POS_W-1:0]    repeatPos = '0;
    logic [`REPEAT_W-1:0] repeatCount = '0;
    logic                 serialPoll, deviceClear, selDeviceClear, listenAddressed, query_header_enable, busy;
    logic                 sweep_end_request_enable, service_request_enable, warning_report_enable, headerEmit;
    logic                 acceptInput, nrfdHold, flushBuffers, replay, proceed, srq;
    int                   n_fail = 0, compares = 0, nRep = 0, nPro = 0, nFl = 0, r0, p0, f0;
    gpib_status_and_exec_control dut (.*, .setHeader(sv[0]), .setSweepEndReq(sv[1]), .setServiceReq(sv[2]),
        .setWarnReport(sv[3]), .cmdError(pv[0]), .execError(pv[1]), .internalError(pv[2]), .execWarning(pv[3]),
        .internalWarning(pv[4]), .holdCmd(pv[5]), .sweepDone(pv[6]), .settingsInit(pv[7]));
    gpib_controller_model ctl (.*);
    always #50 clk_sys = ~clk_sys;
    // Pulse counters
    always @(posedge clk_sys) begin
        if (replay === 1'b1) nRep <= nRep + 1;
        if (proceed === 1'b1) nPro <= nPro + 1;
        if (flushBuffers === 1'b1) nFl <= nFl + 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic fail(input string m);
        n_fail++;
        $display("unexpected at %0t: %s", $time, m);
    endtask : fail
    task automatic chkBit(input logic a, e, input string m);
        compares++;
        if (a !== e) fail(m);
    endtask : chkBit
    task automatic chkByte(input logic [7:0] a, e, input string m);
        compares++;
        if (a !== e) fail(m);
    endtask : chkByte
    task automatic chkCount(input int a, e, input string m);
        compares++;
        if (a != e) fail(m);
    endtask : chkCount
    // One-cycle event pulse
    task automatic pulse(input int i);
        pv <= 8'h01 << i;
        @(posedge clk_sys);
        pv <= 8'h00;
        @(posedge clk_sys);
    endtask : pulse
    // Write one setting
    task automatic set(input int i, input logic v);
        setValue <= v;
        sv <= 4'h1 << i;
        @(posedge clk_sys);
        sv <= 4'h0;
        @(posedge clk_sys);
    endtask : set
    task automatic waitByte(input logic [7:0] e, input string m);
        for (int k = 0; k < 6 && statusByte !== e; k++) @(posedge clk_sys);
        chkByte(statusByte, e, m);
    endtask : waitByte
    // Repeat command, never from a stored macro
    task automatic rep(input logic [7:0] pos, input logic [23:0] n);
        repeatPos <= pos;
        repeatCount <= n;
        repeatCmd <= 1'b1;
        cyc(1);
        repeatCmd <= 1'b0;
        cyc(2);
    endtask : rep
    task automatic t_reset();
        chkBit(query_header_enable, 1'b1, "hdr reset");
        chkBit(sweep_end_request_enable, 1'b0, "eos reset");
        chkBit(service_request_enable, 1'b1, "rqs reset");
        chkBit(warning_report_enable, 1'b1, "warn reset");
        chkByte(statusByte, 8'h00, "idle byte");
    endtask : t_reset
    task automatic t_settings();
        set(0, 1'b0);
        cyc(1);
        chkBit(headerEmit, 1'b0, "header off");
        settingsQuery <= 1'b1;
        cyc(3);
        chkBit(headerEmit, 1'b1, "settings header");
        settingsQuery <= 1'b0;
        set(0, 1'b1);
        cyc(1);
        chkBit(headerEmit, 1'b1, "header on");
        talkOnly <= 1'b1;
        set(2, 1'b1);
        chkBit(service_request_enable, 1'b0, "rqs talk");
        talkOnly <= 1'b0;
        listenOnly <= 1'b1;
        pulse(7);
        chkBit(service_request_enable, 1'b0, "rqs init");
        listenOnly <= 1'b0;
        set(2, 1'b1);
        chkBit(service_request_enable, 1'b1, "rqs on");
    endtask : t_settings
    task automatic t_hold();
        singleSweepMode <= 1'b1;
        p0 = nPro;
        pulse(5);
        cyc(2);
        chkCount(nPro - p0, 1, "unarmed hold");
        single_sweep_arm <= 1'b1;
        ctl.listen(1'b1);
        pulse(5);
        cyc(2);
        chkBit(nrfdHold, 1'b1, "nrfd in hold");
        chkBit(statusByte[4], 1'b1, "busy bit");
        p0 = nPro;
        sweepEndPresent <= 1'b1;
        cyc(4);
        sweepEndPresent <= 1'b0;
        chkBit(busy, 1'b0, "hold end");
        chkCount(nPro - p0, 1, "hold proceed");
        chkBit(statusByte[4], 1'b0, "busy clear");
        execBusy <= 1'b1;
        cyc(3);
        chkBit(acceptInput, 1'b0, "exec busy");
        execBusy <= 1'b0;
        pulse(5);
        f0 = nFl;
        p0 = nPro;
        ctl.clear(1'b1);
        cyc(3);
        chkBit(busy, 1'b0, "sdc hold");
        ctl.listen(1'b0);
        ctl.clear(1'b1);
        pulse(5);
        ctl.clear(1'b0);
        cyc(3);
        chkBit(busy, 1'b0, "dcl hold");
        chkCount(nFl - f0, 2, "flush count");
        chkCount(nPro - p0, 0, "clear proceed");
        singleSweepMode <= 1'b0;
    endtask : t_hold
    task automatic t_repeat();
        r0 = nRep;
        p0 = nPro;
        rep(8'h03, 24'h000002);
        rep(8'h01, 24'h000005);
        rep(8'h03, 24'h000002);
        rep(8'h03, 24'h000002);
        rep(8'h03, 24'h000000);
        rep(8'h05, 24'hFFFFFF);
        ctl.clear(1'b0);
        rep(8'h05, 24'h000000);
        cyc(1);
        chkCount(nRep - r0, 3, "replays");
        chkCount(nPro - p0, 4, "proceeds");
        r0 = nRep;
        p0 = nPro;
        rep(8'h07, 24'h0003E8);
        local_return_button <= 1'b1;
        for (int k = 0; k < 256; k++) rep(8'h07, 24'h0003E8);
        local_return_button <= 1'b0;
        cyc(1);
        chkCount(nRep - r0, 256, "local cap");
        chkCount(nPro - p0, 1, "cap end");
    endtask : t_repeat
    task automatic t_status();
        logic [7:0] codes [5] = '{8'h61, 8'h62, 8'h63, 8'h65, 8'h66};
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            waitByte(codes[i], "event byte");
            ctl.poll(got);
            chkByte(got, codes[i], "polled byte");
            waitByte(8'h00, "poll clears");
        end
        pv <= 8'h01;
        cyc(1);
        pv <= 8'h02;
        cyc(1);
        pv <= 8'h00;
        waitByte(8'h61, "oldest first");
        ctl.poll(got);
        waitByte(8'h62, "stacked next");
        ctl.poll(got);
        set(3, 1'b0);
        pulse(3);
        pulse(4);
        cyc(3);
        chkByte(statusByte, 8'h00, "warn off");
        set(3, 1'b1);
        set(2, 1'b0);
        pulse(0);
        waitByte(8'h21, "masked error");
        ctl.poll(got);
        pulse(6);
        cyc(3);
        chkByte(statusByte, 8'h00, "eos off");
        set(1, 1'b1);
        pulse(6);
        waitByte(8'h02, "eos no srq");
        ctl.poll(got);
        set(2, 1'b1);
        pulse(6);
        waitByte(8'h42, "eos srq");
        ctl.poll(got);
        waitByte(8'h00, "ordinary");
    endtask : t_status
    task automatic t_power();
        srst <= 1'b1;
        optionPowerOn <= 1'b1;
        talkOnly <= 1'b1;
        cyc(5);
        srst <= 1'b0;
        cyc(2);
        optionPowerOn <= 1'b0;
        waitByte(8'h41, "power on");
        ctl.poll(got);
        chkByte(got, 8'h41, "po polled");
        waitByte(8'h00, "po cleared");
        talkOnly <= 1'b0;
    endtask : t_power
    task automatic results();
        if (n_fail == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end
        else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    // Main sequence
    initial begin
        cyc(5);
        srst <= 1'b0;
        cyc(2);
        t_reset();
        t_settings();
        t_hold();
        t_repeat();
        t_status();
        t_power();
        results();
    end
    // Watchdog
    initial begin
        cyc(5000);
        n_fail++;
        results();
    end
endmodule : tb_top
